// *** src/pca_pkg.sv ***
// Package: register map, field positions and reset values of the counter array
package pca_pkg;
	localparam int NUM_MOD = 5;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 6;

	// Register byte offsets
	localparam logic [5:0] OFF_COUNTER_LOW = 6'h00;
	localparam logic [5:0] OFF_COUNTER_HIGH = 6'h01;
	localparam logic [5:0] OFF_COUNTER_MODE = 6'h02;
	localparam logic [5:0] OFF_RUN_FLAGS = 6'h03;
	localparam logic [5:0] OFF_IRQ_STATUS = 6'h04;
	localparam logic [5:0] OFF_IRQ_CLEAR = 6'h05;
	localparam logic [5:0] OFF_IRQ_ENABLE = 6'h06;
	localparam logic [5:0] OFF_MODE_BASE = 6'h08;
	localparam logic [5:0] OFF_VAL_LOW_BASE = 6'h10;
	localparam logic [5:0] OFF_VAL_HIGH_BASE = 6'h18;

	// Counter mode register fields
	localparam int CMODE_IDLE_STOP = 7;
	localparam int CMODE_WDOG_EN = 6;
	localparam int CMODE_SRC_HI = 2;
	localparam int CMODE_SRC_LO = 1;
	localparam int CMODE_OVF_IRQ = 0;

	// Run and flags register fields
	localparam int RF_OVF_FLAG = 7;
	localparam int RF_RUN = 6;

	// Module mode register fields
	localparam int MM_IRQ_EN = 0;
	localparam int MM_PWM = 1;
	localparam int MM_TOGGLE = 2;
	localparam int MM_MATCH = 3;
	localparam int MM_FALL_CAP = 4;
	localparam int MM_RISE_CAP = 5;
	localparam int MM_COMP_EN = 6;

	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [1:0] SRC_DIV6A = 2'h0;
	localparam logic [1:0] SRC_FAST = 2'h1;
	localparam logic [1:0] SRC_TIMER0 = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	localparam int PRESCALE_DIV = 6;
	localparam int PRESCALE_FAST_DIV = 2;

	// Interrupt status bit: bits 0..4 module events, bit 5 overflow
	localparam int IRQ_OVF_BIT = 5;
endpackage

// *** src/pca_top.sv ***
// Top: counter array with shared 16-bit time base and five capture/compare modules
// Operation
// - One free-running 16-bit shared up counter
// - Counter readable as high and low bytes
// - Two-bit select picks count source
// - Idle-stop bit halts counter during idle
// - Watchdog enable bit acts on module 4
// - Overflow sets flag; interrupt needs enable
// - Overflow flag cleared only by software
// - Run bit gates the counter
// - Control bits 0-4 are module flags
// - All events share one interrupt request
// - Mode bit 0 enables module interrupt
// - Mode bit 1 selects PWM output
// - Mode bit 2 toggles pin on match
// - Mode bit 3 sets flag on match
// - Mode bits 4/5 select capture edges
// - Mode bit 6 enables comparator
// - Capture latches counter into module registers
// - Each module owns pin, four modes
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pca_top #(
	parameter int NUM_MODULES = pca_pkg::NUM_MOD, // Capture/compare modules
	parameter int COUNT_WIDTH = pca_pkg::CNT_W    // Time base width
) (
	input  wire logic       REF_CLK_I,        // 125 MHz clock
	input  wire logic       SYS_RST_I,        // Sync reset, high
	input  wire logic [5:0] ADDR_I,           // Register byte address
	input  wire logic [7:0] WDATA_I,          // Write data
	input  wire logic       WR_I,             // Write strobe
	input  wire logic       RD_I,             // Read strobe
	output logic      [7:0] RDATA_O,          // Read data, cycle after strobe
	input  wire logic       IDLE_I,           // Processor idle mode
	input  wire logic       TIMER0_OVF_I,     // Timer 0 overflow pulse
	input  wire logic       EXT_COUNT_I,      // External count input level
	input  wire logic [4:0] MODULE_PIN_I,     // Module pins, capture side
	output logic      [4:0] MODULE_PIN_O,     // Module pins, output side
	output logic            WDOG_RESET_O,     // Module 4 watchdog match pulse
	output logic            PCA_IRQ_O,        // Shared counter interrupt
	output logic            IRQ_O             // Status/enable interrupt level
);
	localparam int N = NUM_MODULES;

	// Ports and register map are laid out for five modules on a 16-bit base
	if (NUM_MODULES != 5) begin : g_bad_mods
		$error("NUM_MODULES must be 5");
	end
	if (COUNT_WIDTH != 16) begin : g_bad_width
		$error("COUNT_WIDTH must be 16");
	end

	logic [15:0] counter;
	logic [7:0]  counter_mode_reg;
	logic        counter_overflow_flag;
	logic        counter_run;
	logic [4:0]  module_event_flag;
	logic [7:0]  module_mode_control [N];
	logic [7:0]  module_value_low [N];
	logic [7:0]  module_value_high [N];
	logic [4:0]  pin_out;
	logic [4:0]  pin_prev;
	logic [2:0]  prescale;
	logic        fast_phase;
	logic [4:0]  module_irq;
	logic        ext_prev;
	logic        tick;
	logic        count_en;
	logic        overflow;
	logic [4:0]  match_ev;
	logic [4:0]  capture_ev;
	logic [4:0]  next_event_flag;
	logic [5:0]  irq_status;
	logic [5:0]  irq_enable;
	logic [7:0]  next_rdata;

	wire wr_run = WR_I && ADDR_I == pca_pkg::OFF_RUN_FLAGS;

	// ----------------------------------------------------------------
	// Count source and time base
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I || prescale == 3'(pca_pkg::PRESCALE_DIV - 1)) begin
			prescale <= 3'h0;
		end else begin
			prescale <= prescale + 3'h1;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I || fast_phase == 1'(pca_pkg::PRESCALE_FAST_DIV - 1)) begin
			fast_phase <= 1'b0;
		end else begin
			fast_phase <= fast_phase + 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= EXT_COUNT_I;
		end
	end

	// Slow and fast dividers run free, so the first step after run has a loose phase
	always_comb begin
		case (counter_mode_reg[pca_pkg::CMODE_SRC_HI:pca_pkg::CMODE_SRC_LO])
			pca_pkg::SRC_FAST:   tick = fast_phase == 1'(pca_pkg::PRESCALE_FAST_DIV - 1);
			pca_pkg::SRC_TIMER0: tick = TIMER0_OVF_I;
			pca_pkg::SRC_EXT:    tick = ext_prev && !EXT_COUNT_I;
			default:             tick = prescale == 3'(pca_pkg::PRESCALE_DIV - 1);
		endcase
	end

	assign count_en = tick && counter_run
		&& !(IDLE_I && counter_mode_reg[pca_pkg::CMODE_IDLE_STOP]);
	assign overflow = count_en && counter == 16'hffff;

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			counter <= 16'h0000;
		end else if (WR_I && ADDR_I == pca_pkg::OFF_COUNTER_LOW) begin
			counter[7:0] <= WDATA_I;
		end else if (WR_I && ADDR_I == pca_pkg::OFF_COUNTER_HIGH) begin
			counter[15:8] <= WDATA_I;
		end else if (count_en) begin
			counter <= counter + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			counter_mode_reg <= pca_pkg::RST_REG;
		end else if (WR_I && ADDR_I == pca_pkg::OFF_COUNTER_MODE) begin
			counter_mode_reg <= WDATA_I & 8'hc7;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			counter_run <= 1'b0;
		end else if (wr_run) begin
			counter_run <= WDATA_I[pca_pkg::RF_RUN];
		end
	end

	// Software may set or clear; hardware only sets, and a set beats a clear
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			counter_overflow_flag <= 1'b0;
		end else if (overflow) begin
			counter_overflow_flag <= 1'b1;
		end else if (wr_run) begin
			counter_overflow_flag <= WDATA_I[pca_pkg::RF_OVF_FLAG];
		end
	end

	always_comb begin
		next_event_flag = wr_run ? WDATA_I[4:0] : module_event_flag;
		next_event_flag = next_event_flag | match_ev | capture_ev;
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			module_event_flag <= 5'h00;
		end else begin
			module_event_flag <= next_event_flag;
		end
	end

	// ----------------------------------------------------------------
	// Capture/compare modules
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_mod
			wire [7:0]  mm = module_mode_control[g];
			wire [15:0] val = {module_value_high[g], module_value_low[g]};
			wire        rise = !pin_prev[g] && MODULE_PIN_I[g];
			wire        fall = pin_prev[g] && !MODULE_PIN_I[g];
			// Compared only on a count step, so one counter value gives one match
			wire        hit = mm[pca_pkg::MM_COMP_EN] && count_en
				&& counter + 16'h0001 == val;

			assign match_ev[g] = hit && mm[pca_pkg::MM_MATCH];
			assign module_irq[g] = module_event_flag[g] && mm[pca_pkg::MM_IRQ_EN];
			assign capture_ev[g] = (rise && mm[pca_pkg::MM_RISE_CAP])
				|| (fall && mm[pca_pkg::MM_FALL_CAP]);

			always_ff @(posedge REF_CLK_I) begin
				if (SYS_RST_I) begin
					pin_prev[g] <= 1'b0;
				end else begin
					pin_prev[g] <= MODULE_PIN_I[g];
				end
			end

			always_ff @(posedge REF_CLK_I) begin
				if (SYS_RST_I) begin
					module_mode_control[g] <= pca_pkg::RST_REG;
				end else if (WR_I && ADDR_I == pca_pkg::OFF_MODE_BASE + 6'(g)) begin
					module_mode_control[g] <= WDATA_I & 8'h7f;
				end
			end

			always_ff @(posedge REF_CLK_I) begin
				if (SYS_RST_I) begin
					module_value_low[g] <= 8'h00;
					module_value_high[g] <= 8'h00;
				end else if (capture_ev[g]) begin
					{module_value_high[g], module_value_low[g]} <= counter;
				end else begin
					if (WR_I && ADDR_I == pca_pkg::OFF_VAL_LOW_BASE + 6'(g)) begin
						module_value_low[g] <= WDATA_I;
					end
					if (WR_I && ADDR_I == pca_pkg::OFF_VAL_HIGH_BASE + 6'(g)) begin
						module_value_high[g] <= WDATA_I;
					end
				end
			end

			// PWM: low while counter below value, else high; otherwise toggle on match
			always_ff @(posedge REF_CLK_I) begin
				if (SYS_RST_I) begin
					pin_out[g] <= 1'b1;
				end else if (mm[pca_pkg::MM_PWM] && mm[pca_pkg::MM_COMP_EN]) begin
					pin_out[g] <= !(counter < val);
				end else if (hit && mm[pca_pkg::MM_TOGGLE]) begin
					pin_out[g] <= !pin_out[g];
				end
			end
		end
	endgenerate

	assign MODULE_PIN_O = pin_out;

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			WDOG_RESET_O <= 1'b0;
		end else begin
			WDOG_RESET_O <= match_ev[4] && counter_mode_reg[pca_pkg::CMODE_WDOG_EN];
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			PCA_IRQ_O <= 1'b0;
		end else begin
			PCA_IRQ_O <= (counter_overflow_flag && counter_mode_reg[pca_pkg::CMODE_OVF_IRQ])
				|| |module_irq;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			irq_status <= 6'h00;
		end else begin
			irq_status <= ((WR_I && ADDR_I == pca_pkg::OFF_IRQ_CLEAR)
				? irq_status & ~WDATA_I[5:0] : irq_status)
				| {overflow, match_ev | capture_ev};
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			irq_enable <= 6'h00;
		end else if (WR_I && ADDR_I == pca_pkg::OFF_IRQ_ENABLE) begin
			irq_enable <= WDATA_I[5:0];
		end
	end

	assign IRQ_O = |(irq_status & irq_enable);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (ADDR_I == pca_pkg::OFF_COUNTER_LOW) begin
			next_rdata = counter[7:0];
		end else if (ADDR_I == pca_pkg::OFF_COUNTER_HIGH) begin
			next_rdata = counter[15:8];
		end else if (ADDR_I == pca_pkg::OFF_COUNTER_MODE) begin
			next_rdata = counter_mode_reg;
		end else if (ADDR_I == pca_pkg::OFF_RUN_FLAGS) begin
			next_rdata = {counter_overflow_flag, counter_run, 1'b0, module_event_flag};
		end else if (ADDR_I == pca_pkg::OFF_IRQ_STATUS) begin
			next_rdata = {2'h0, irq_status};
		end else if (ADDR_I == pca_pkg::OFF_IRQ_ENABLE) begin
			next_rdata = {2'h0, irq_enable};
		end else if (ADDR_I >= pca_pkg::OFF_MODE_BASE && ADDR_I < pca_pkg::OFF_MODE_BASE + 6'h05) begin
			next_rdata = module_mode_control[3'(ADDR_I - pca_pkg::OFF_MODE_BASE)];
		end else if (ADDR_I >= pca_pkg::OFF_VAL_LOW_BASE
			&& ADDR_I < pca_pkg::OFF_VAL_LOW_BASE + 6'h05) begin
			next_rdata = module_value_low[3'(ADDR_I - pca_pkg::OFF_VAL_LOW_BASE)];
		end else if (ADDR_I >= pca_pkg::OFF_VAL_HIGH_BASE
			&& ADDR_I < pca_pkg::OFF_VAL_HIGH_BASE + 6'h05) begin
			next_rdata = module_value_high[3'(ADDR_I - pca_pkg::OFF_VAL_HIGH_BASE)];
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			RDATA_O <= 8'h00;
		end else if (RD_I) begin
			RDATA_O <= next_rdata;
		end else begin
			RDATA_O <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// *** verification/pca_checker.sv ***
// Checker: port-level properties of the counter array
`timescale 1ns/100ps
`default_nettype none
module pca_checker (
	input wire logic       REF_CLK_I,    // Clock
	input wire logic       SYS_RST_I,    // Reset
	input wire logic [5:0] ADDR_I,       // Address
	input wire logic [7:0] WDATA_I,      // Write data
	input wire logic       WR_I,         // Write
	input wire logic       RD_I,         // Read
	input wire logic [7:0] RDATA_O,      // Read data
	input wire logic [4:0] MODULE_PIN_O, // Pins
	input wire logic       WDOG_RESET_O, // Watchdog
	input wire logic       PCA_IRQ_O,    // Counter irq
	input wire logic       IRQ_O         // Status irq
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	chk_read_slot: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data outside its slot");
	chk_flag_resv: assert property (RD_I && ADDR_I == pca_pkg::OFF_RUN_FLAGS |=> !RDATA_O[5])
		else $error("reserved flag bit read as one");
	chk_mode_resv: assert property (RD_I && ADDR_I == pca_pkg::OFF_COUNTER_MODE |=> RDATA_O[5:3] == 3'h0)
		else $error("reserved mode bits read nonzero");
	chk_wdog_once: assert property (WDOG_RESET_O |=> !WDOG_RESET_O)
		else $error("watchdog pulse too long");
	chk_reset_out: assert property ($fell(SYS_RST_I) |-> MODULE_PIN_O == 5'h1f && !PCA_IRQ_O && !IRQ_O)
		else $error("outputs wrong after reset");
	chk_mask_off: assert property (WR_I && ADDR_I == pca_pkg::OFF_IRQ_ENABLE && WDATA_I == 8'h00 |=> !IRQ_O)
		else $error("interrupt with all enables off");
	chk_flag_sticky: assert property ($fell(PCA_IRQ_O) |-> $past(WR_I) || $past(WR_I, 2))
		else $error("counter irq fell without a write");
	chk_stat_sticky: assert property ($fell(IRQ_O) |-> $past(WR_I))
		else $error("status irq fell without a write");
	cover property (WDOG_RESET_O);
	cover property ($rose(PCA_IRQ_O));
	cover property ($changed(MODULE_PIN_O));
endmodule
bind pca_top pca_checker u_chk (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MODULE_PIN_O(MODULE_PIN_O),
	.WDOG_RESET_O(WDOG_RESET_O), .PCA_IRQ_O(PCA_IRQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

// *** verification/pca_pins_model.sv ***
// Partner model: capture pins, timer 0 overflow and external count input
`timescale 1ns/100ps
`default_nettype none
module pca_pins_model (
	input  wire logic       clk_i, // Clock
	output var  logic       t0_o,  // Overflow pulse
	output var  logic       ext_o, // Count input
	output var  logic [4:0] pin_o  // Capture pins
);
	initial begin
		t0_o = 1'b0;
		ext_o = 1'b1;
		pin_o = 5'h00;
	end
	// Count input idles high; one low cycle then at least four high keeps it under a quarter rate
	task automatic tick(input logic ext);
		@(posedge clk_i);
		t0_o <= !ext;
		ext_o <= !ext;
		@(posedge clk_i);
		t0_o <= 1'b0;
		ext_o <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic set_pin(input int i, input logic v);
		@(posedge clk_i);
		pin_o[i] <= v;
		repeat (3) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// *** verification/pca_top_tb.sv ***
// Testbench: bus, counting, rollover, compare and capture of the counter array
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("BAD %s exp %h got %h", n, e, g); \
	end \
end
module pca_top_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  addr = 6'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        idle = 1'b0;
	logic [7:0]  rdata;
	logic [4:0]  pin_i, pin_o;
	logic        t0, ext, wdog, pirq, irq;
	logic [15:0] cnt;
	int          bad_count = 0;
	int          n_checks = 0;
	int          wd_seen = 0;
	int          seed = 32'hbdb3;
	int          n;

	always #4 clk = ~clk;
	always @(posedge clk) if (wdog) wd_seen++;
	pca_top dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .IDLE_I(idle), .TIMER0_OVF_I(t0), .EXT_COUNT_I(ext),
		.MODULE_PIN_I(pin_i), .MODULE_PIN_O(pin_o), .WDOG_RESET_O(wdog), .PCA_IRQ_O(pirq),
		.IRQ_O(irq));
	pca_pins_model pins (.clk_i(clk), .t0_o(t0), .ext_o(ext), .pin_o(pin_i));

	function automatic logic [7:0] flags(input logic ovf, input logic run, input logic [4:0] f);
		return {ovf, run, 1'b0, f};
	endfunction
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK($sformatf("reg %h", a), e & m, rdata & m)
	endtask
	task automatic count(input int k, input logic ext_src, input logic on);
		repeat (k) pins.tick(ext_src);
		if (on) cnt = cnt + 16'(k);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		bad_count++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cnt = 16'h0000;
		for (int a = 0; a < 32; a++) rd_chk(6'(a), 8'h00, 8'hff);
		$display("test reset values done");
		// Timer 0 and count pin; ticks after run clears must be lost
		for (int s = 2; s < 4; s++) begin
			n = 1 + (($random(seed) & 32'h7fffffff) % 20);
			wr_reg(pca_pkg::OFF_COUNTER_MODE, 8'(s << 1));
			wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h40);
			count(n, s == 3, 1'b1);
			wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h00);
			count(2, s == 3, 1'b0);
			rd_chk(pca_pkg::OFF_COUNTER_LOW, cnt[7:0], 8'hff);
			rd_chk(pca_pkg::OFF_COUNTER_HIGH, cnt[15:8], 8'hff);
		end
		wr_reg(pca_pkg::OFF_COUNTER_MODE, 8'h84);
		wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h40);
		idle <= 1'b1;
		count(3, 1'b0, 1'b0);
		wr_reg(pca_pkg::OFF_COUNTER_MODE, 8'h04);
		count(2, 1'b0, 1'b1);
		idle <= 1'b0;
		rd_chk(pca_pkg::OFF_COUNTER_LOW, cnt[7:0], 8'hff);
		// Prescaled sources over 61 run edges: about 10 slow or 30 fast steps
		for (int s = 0; s < 2; s++) begin
			wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h00);
			wr_reg(pca_pkg::OFF_COUNTER_LOW, 8'h00);
			wr_reg(pca_pkg::OFF_COUNTER_MODE, 8'(s << 1));
			wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h40);
			repeat (59) @(posedge clk);
			wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h00);
			rd_chk(pca_pkg::OFF_COUNTER_LOW, (s == 0) ? 8'h08 : 8'h10, 8'hf0);
		end
		$display("test count sources done");
		wr_reg(pca_pkg::OFF_COUNTER_LOW, 8'hff);
		wr_reg(pca_pkg::OFF_COUNTER_HIGH, 8'hff);
		wr_reg(pca_pkg::OFF_COUNTER_MODE, 8'h05);
		wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h40);
		cnt = 16'hffff;
		count(2, 1'b0, 1'b1);
		rd_chk(pca_pkg::OFF_RUN_FLAGS, flags(1'b1, 1'b1, 5'h00), 8'hff);
		rd_chk(pca_pkg::OFF_COUNTER_HIGH, cnt[15:8], 8'hff);
		`CHK("pca_irq", 1'b1, pirq)
		rd_chk(pca_pkg::OFF_IRQ_STATUS, 8'h20, 8'hff);
		wr_reg(pca_pkg::OFF_IRQ_ENABLE, 8'h3f);
		`CHK("irq", 1'b1, irq)
		wr_reg(pca_pkg::OFF_IRQ_ENABLE, 8'h00);
		`CHK("irq masked", 1'b0, irq)
		wr_reg(pca_pkg::OFF_IRQ_CLEAR, 8'h20);
		wr_reg(pca_pkg::OFF_IRQ_ENABLE, 8'h3f);
		`CHK("irq cleared", 1'b0, irq)
		wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h40);
		rd_chk(pca_pkg::OFF_RUN_FLAGS, flags(1'b0, 1'b1, 5'h00), 8'hff);
		`CHK("pca_irq off", 1'b0, pirq)
		$display("test rollover done");
		// Module 1 toggles and flags, module 4 fires the watchdog pulse
		n = 1 + (($random(seed) & 32'h7fffffff) % 8);
		for (int m = 1; m < 5; m += 3) begin
			wr_reg(pca_pkg::OFF_VAL_LOW_BASE + 6'(m), cnt[7:0] + 8'(n));
			wr_reg(pca_pkg::OFF_VAL_HIGH_BASE + 6'(m), cnt[15:8]);
		end
		wr_reg(pca_pkg::OFF_MODE_BASE + 6'h01, 8'h4d);
		wr_reg(pca_pkg::OFF_MODE_BASE + 6'h04, 8'h48);
		wr_reg(pca_pkg::OFF_COUNTER_MODE, 8'h44);
		count(n + 2, 1'b0, 1'b1);
		`CHK("pins", 5'h1d, pin_o)
		`CHK("wdog pulses", 1, wd_seen)
		rd_chk(pca_pkg::OFF_RUN_FLAGS, flags(1'b0, 1'b1, 5'h12), 8'hff);
		`CHK("pca_irq match", 1'b1, pirq)
		wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h50);
		rd_chk(pca_pkg::OFF_IRQ_STATUS, 8'h12, 8'hff);
		`CHK("pca_irq unenabled", 1'b0, pirq)
		// Module 2 takes a rise; module 3 ignores the rise and takes the fall
		wr_reg(pca_pkg::OFF_MODE_BASE + 6'h02, 8'h20);
		wr_reg(pca_pkg::OFF_MODE_BASE + 6'h03, 8'h10);
		wr_reg(pca_pkg::OFF_RUN_FLAGS, 8'h00);
		pins.set_pin(2, 1'b1);
		pins.set_pin(3, 1'b1);
		rd_chk(pca_pkg::OFF_RUN_FLAGS, flags(1'b0, 1'b0, 5'h04), 8'hff);
		rd_chk(pca_pkg::OFF_VAL_LOW_BASE + 6'h02, cnt[7:0], 8'hff);
		rd_chk(pca_pkg::OFF_VAL_HIGH_BASE + 6'h02, cnt[15:8], 8'hff);
		pins.set_pin(3, 1'b0);
		rd_chk(pca_pkg::OFF_VAL_LOW_BASE + 6'h03, cnt[7:0], 8'hff);
		// Module 0 PWM: low while counter below value, high once value drops to it
		wr_reg(pca_pkg::OFF_VAL_LOW_BASE, cnt[7:0] + 8'h01);
		wr_reg(pca_pkg::OFF_VAL_HIGH_BASE, cnt[15:8]);
		wr_reg(pca_pkg::OFF_MODE_BASE, 8'h42);
		wr_reg(pca_pkg::OFF_VAL_LOW_BASE, cnt[7:0]);
		`CHK("pwm low", 5'h1c, pin_o)
		rd_chk(pca_pkg::OFF_MODE_BASE, 8'h42, 8'hff);
		`CHK("pwm high", 5'h1d, pin_o)
		$display("test compare and capture done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
